// ---- core/sip_decode.sv ----
// Instruction length and type decoder for the decode stage
`timescale 1ns/1ps
module sip_decode
  import sip_pkg::*;
(
  // Instruction bytes
  input  wire logic [INSN_W-1:0] bytes_in,
  // Decoded fields
  output logic      [LEN_W-1:0]  len,
  output sip_type_t              itype,
  output logic                   mem_ref,
  output logic      [ADDR_W-1:0] disp
);
  logic [7:0] op;
  assign op = bytes_in[7:0];

  always_comb begin
    len     = 4'd1;
    itype   = SIP_T_ALU;
    mem_ref = 1'b0;
    disp    = bytes_in[39:8];
    if (op == OP_JMP) begin
      len   = 4'd5;
      itype = SIP_T_BRANCH;
    end else if (op >= OP_JCC_LO && op <= OP_JCC_HI) begin
      len   = 4'd2;
      itype = SIP_T_BRANCH;
      disp  = {{24{bytes_in[15]}}, bytes_in[15:8]};
    end else if (op >= OP_FPU_LO && op <= OP_FPU_HI) begin
      len     = 4'd6;
      itype   = SIP_T_FPU;
      mem_ref = 1'b1;
      disp    = bytes_in[47:16];
    end else if (op == OP_STORE || op == OP_MEMMOD) begin
      len     = 4'd6;
      itype   = (op == OP_STORE) ? SIP_T_STORE : SIP_T_LOAD;
      mem_ref = 1'b1;
      disp    = bytes_in[47:16];
    end
  end
endmodule

// ---- core/sip_pipe.sv ----
// Six-stage integer pipeline sequencing and control
`timescale 1ns/1ps
module sip_pipe
  import sip_pkg::*;
(
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  // Code fetch from cache
  output logic                      ifetch_req,
  output logic      [ADDR_W-1:0]    ifetch_addr,
  input  wire logic                 ifetch_ack,
  input  wire logic [FETCH_W-1:0]   ifetch_data,
  // Operand access via translation and cache
  output logic                      dmem_req,
  output logic      [ADDR_W-1:0]    dmem_lin_addr,
  input  wire logic                 dmem_ack,
  input  wire logic                 dmem_fault,
  input  wire logic [BUS_W-1:0]     dmem_rdata,
  // Floating-point dispatch
  output logic                      fpu_valid,
  output logic      [INSN_W-1:0]    fpu_insn,
  output logic      [BUS_W-1:0]     fpu_operand,
  input  wire logic                 fpu_ready,
  // Store hand-off to load/store unit
  output logic                      lsu_valid,
  output logic      [ADDR_W-1:0]    lsu_addr,
  output logic      [BUS_W-1:0]     lsu_wdata,
  input  wire logic                 lsu_ready,
  // Register file write and branch resolution
  output logic                      rf_we,
  output logic      [REG_IDX_W-1:0] rf_waddr,
  output logic      [BUS_W-1:0]     rf_wdata,
  input  wire logic                 br_taken,
  output logic                      mispredict,
  output logic                      mem_fault
);
  // ----------------------------------------
  // Stage registers
  // ----------------------------------------
  logic [ADDR_W-1:0]  pc_reg;
  logic [FETCH_W-1:0] q_data_reg [QUEUE_SLOTS];
  logic [4:0]         q_rd_reg;
  logic [1:0]         q_cnt_reg;
  logic               de_v_reg, a1_v_reg, a2_v_reg, ex_v_reg, wb_v_reg;
  logic [INSN_W-1:0]  de_i_reg, a1_i_reg, a2_i_reg, ex_i_reg;
  sip_type_t          a1_t_reg, a2_t_reg, ex_t_reg, wb_t_reg;
  logic [ADDR_W-1:0]  de_pc_reg, a1_pc_reg, a2_pc_reg, ex_pc_reg;
  logic [ADDR_W-1:0]  de_ipc_reg;
  logic [ADDR_W-1:0]  a1_tgt_reg, a2_tgt_reg, ex_tgt_reg;
  logic [ADDR_W-1:0]  a2_lin_reg, ex_lin_reg, wb_lin_reg;
  logic               a1_mem_reg, a2_mem_reg;
  logic [BUS_W-1:0]   ex_opnd_reg, wb_res_reg;
  logic [REG_IDX_W-1:0] wb_idx_reg;
  logic [BUS_W-1:0]   rfile_reg [8];
  logic               fault_reg;
  sip_ex_t            ex_st_reg;
  logic [UPC_W-1:0]   upc_reg;

  // ----------------------------------------
  // Decode of queued bytes
  // ----------------------------------------
  logic [3*FETCH_W-1:0] q_flat;
  logic [INSN_W-1:0]    q_head;
  logic [LEN_W-1:0]     d_len;
  sip_type_t            d_type;
  logic                 d_mem;
  logic [ADDR_W-1:0]    d_disp;
  logic [5:0]           q_bytes;

  assign q_flat = {q_data_reg[2], q_data_reg[1], q_data_reg[0]};
  assign q_head = INSN_W'(q_flat >> {q_rd_reg, 3'b000});
  assign q_bytes = 6'(q_cnt_reg) * 6'(FETCH_BYTES) - 6'(q_rd_reg % 16);

  sip_decode u_dec (
    .bytes_in (q_head),
    .len      (d_len),
    .itype    (d_type),
    .mem_ref  (d_mem),
    .disp     (d_disp)
  );

  // Second decoder types the instruction held in the decode stage
  sip_type_t            e_type;
  logic                 e_mem;
  logic [ADDR_W-1:0]    e_disp;

  sip_decode u_dec_de (
    .bytes_in (de_i_reg),
    .len      (),
    .itype    (e_type),
    .mem_ref  (e_mem),
    .disp     (e_disp)
  );

  // ----------------------------------------
  // Stall and flush control
  // ----------------------------------------
  logic ex_busy, wb_stall, ex_stall, a2_stall, a1_stall, de_stall, flush;
  logic a2_fpu_wait, a2_mem_wait, q_have, d_branch, ex_take;

  assign wb_stall    = wb_v_reg && wb_t_reg == SIP_T_STORE && !lsu_ready;
  assign ex_busy     = ex_v_reg && ex_st_reg != SIP_EX_DONE;
  assign ex_stall    = wb_stall || ex_busy;
  assign a2_mem_wait = a2_v_reg && a2_mem_reg && !dmem_ack;
  assign a2_fpu_wait = a2_v_reg && a2_t_reg == SIP_T_FPU && !fpu_ready;
  assign a2_stall    = (ex_stall && a2_v_reg) || a2_mem_wait || a2_fpu_wait;
  assign a1_stall    = a2_stall && a1_v_reg;
  assign ex_take     = a2_v_reg && !a2_stall && a2_t_reg != SIP_T_FPU;
  assign de_stall    = a1_stall && de_v_reg;
  // Resolve at end of execute; redirect on predicted vs actual
  assign flush = ex_v_reg && ex_t_reg == SIP_T_BRANCH && ex_st_reg ==
                 SIP_EX_DONE && !ex_stall && !br_taken;
  assign mispredict = flush;
  // Whole instruction must be present; worst case six bytes
  assign q_have   = q_cnt_reg != 2'd0 && q_bytes >= 6'(d_len);
  assign d_branch = q_have && !de_stall && d_type == SIP_T_BRANCH;

  // ----------------------------------------
  // Fetch and prefetch queue
  // ----------------------------------------
  // Only fetch when a full 16-byte slot is free, so no partial writes
  assign ifetch_req  = !flush && q_cnt_reg != 2'(QUEUE_SLOTS);
  assign ifetch_addr = pc_reg;
  logic pop, retire;
  logic [4:0] rd_next;
  logic [ADDR_W-1:0] de_pc_next;
  assign rd_next = q_rd_reg + 5'(d_len);
  assign pop = q_have && !de_stall && !flush;
  assign retire = pop && rd_next >= 5'(FETCH_BYTES);
  assign de_pc_next = de_pc_reg + ADDR_W'(d_len);

  always_ff @(posedge clk) begin
    if (!rst_n || flush) begin
      pc_reg <= !rst_n ? RESET_PC : ex_pc_reg + ADDR_W'(4'd2);
    end else if (d_branch) begin
      // Predict taken: redirect next cycle, later fetches discarded
      pc_reg <= de_pc_next + d_disp;
    end else if (ifetch_req && ifetch_ack) begin
      pc_reg <= pc_reg + ADDR_W'(FETCH_BYTES);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || flush || d_branch) begin
      q_rd_reg  <= 5'd0;
      q_cnt_reg <= 2'd0;
    end else begin
      // Shift queue: slot retires when read pointer crosses 16
      if (retire) begin
        q_rd_reg <= rd_next - 5'(FETCH_BYTES);
        q_data_reg[0] <= q_data_reg[1];
        q_data_reg[1] <= q_data_reg[2];
      end else if (pop) begin
        q_rd_reg <= rd_next;
      end
      // Fill comes after the shift so it wins its slot
      if (ifetch_req && ifetch_ack) begin
        q_data_reg[q_cnt_reg - 2'(retire)] <= ifetch_data;
      end
      q_cnt_reg <= q_cnt_reg + 2'(ifetch_req && ifetch_ack) - 2'(retire);
    end
  end

  // ----------------------------------------
  // Decode stage
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      de_v_reg  <= 1'b0;
      de_pc_reg <= RESET_PC;
      de_i_reg  <= '0;
    end else if (flush) begin
      de_v_reg  <= 1'b0;
      de_pc_reg <= ex_pc_reg + ADDR_W'(4'd2);
    end else if (!de_stall) begin
      de_v_reg <= pop;
      de_i_reg <= q_head;
      if (pop) begin
        de_ipc_reg <= de_pc_reg;
        de_pc_reg <= d_branch ? de_pc_next + d_disp : de_pc_next;
      end
    end
  end

  // ----------------------------------------
  // Address stages
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n || flush) begin
      a1_v_reg <= 1'b0;
      a2_v_reg <= 1'b0;
    end else begin
      if (!a1_stall) begin
        a1_v_reg   <= de_v_reg;
        a1_i_reg   <= de_i_reg;
        a1_t_reg   <= e_type;
        a1_mem_reg <= e_mem;
        a1_pc_reg  <= de_ipc_reg;
        a1_tgt_reg <= e_disp;
      end
      if (!a2_stall) begin
        a2_v_reg   <= a1_v_reg;
        a2_i_reg   <= a1_i_reg;
        a2_t_reg   <= a1_t_reg;
        a2_mem_reg <= a1_mem_reg;
        a2_pc_reg  <= a1_pc_reg;
        a2_tgt_reg <= a1_tgt_reg;
        a2_lin_reg <= a1_tgt_reg;
      end
    end
  end

  // Second address stage access and FPU dispatch
  assign dmem_req      = a2_v_reg && a2_mem_reg && !flush;
  assign dmem_lin_addr = a2_lin_reg;
  // Dispatch only after the operand returns without fault
  assign fpu_valid = a2_v_reg && a2_t_reg == SIP_T_FPU && dmem_ack
                     && !dmem_fault && !ex_stall && !flush;
  assign fpu_insn    = a2_i_reg;
  assign fpu_operand = dmem_rdata;
  assign mem_fault   = fault_reg;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fault_reg <= 1'b0;
    end else begin
      fault_reg <= a2_v_reg && a2_mem_reg && dmem_ack && dmem_fault;
    end
  end

  // ----------------------------------------
  // Execute stage
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n || flush) begin
      ex_v_reg <= 1'b0;
    end else if (!ex_stall) begin
      // FPU work leaves integer pipe once dispatched
      ex_v_reg <= ex_take;
      ex_i_reg    <= a2_i_reg;
      ex_t_reg    <= a2_t_reg;
      ex_pc_reg   <= a2_pc_reg;
      ex_tgt_reg  <= a2_tgt_reg;
      ex_lin_reg  <= a2_lin_reg;
      ex_opnd_reg <= a2_mem_reg ? dmem_rdata
                                : rfile_reg[a2_i_reg[10:8]];
    end
  end

  // Microcode sequencer; length held in opcode bits
  always_ff @(posedge clk) begin
    if (!rst_n || flush) begin
      ex_st_reg <= SIP_EX_IDLE;
      upc_reg   <= '0;
    end else begin
      unique case (ex_st_reg)
        SIP_EX_IDLE: begin
          if (!ex_stall && ex_take) begin
            ex_st_reg <= SIP_EX_RUN;
            upc_reg   <= {6'd0, a2_i_reg[1:0]};
          end
        end
        SIP_EX_RUN: begin
          if (upc_reg == '0) ex_st_reg <= SIP_EX_DONE;
          else upc_reg <= upc_reg - UPC_ONE;
        end
        SIP_EX_DONE: begin
          // Back-to-back work must restart here or execute locks up
          if (!wb_stall && ex_take) begin
            ex_st_reg <= SIP_EX_RUN;
            upc_reg   <= {6'd0, a2_i_reg[1:0]};
          end else if (!wb_stall) begin
            ex_st_reg <= SIP_EX_IDLE;
          end
        end
        default: ex_st_reg <= SIP_EX_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Write-back stage
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wb_v_reg <= 1'b0;
      wb_t_reg <= SIP_T_ALU;
    end else if (!wb_stall) begin
      wb_v_reg   <= ex_v_reg && ex_st_reg == SIP_EX_DONE && !flush;
      wb_t_reg   <= ex_t_reg;
      wb_lin_reg <= ex_lin_reg;
      wb_idx_reg <= ex_i_reg[10:8];
      wb_res_reg <= ex_opnd_reg + BUS_W'(ex_i_reg[23:16]);
    end
  end

  assign rf_we     = wb_v_reg && (wb_t_reg == SIP_T_ALU ||
                                  wb_t_reg == SIP_T_LOAD);
  assign rf_waddr  = wb_idx_reg;
  assign rf_wdata  = wb_res_reg;
  assign lsu_valid = wb_v_reg && wb_t_reg == SIP_T_STORE;
  assign lsu_addr  = wb_lin_reg;
  assign lsu_wdata = wb_res_reg;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < 8; i++) rfile_reg[i] <= '0;
    end else if (rf_we) begin
      rfile_reg[wb_idx_reg] <= wb_res_reg;
    end
  end
endmodule

// ---- core/sip_pkg.sv ----
// Constants and types for the six-stage integer pipeline control
package sip_pkg;
  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int FETCH_W    = 128;
  localparam int FETCH_BYTES = 16;
  localparam int QUEUE_BYTES = 48;
  localparam int QUEUE_SLOTS = 3;
  localparam int BUS_W      = 64;
  localparam int ADDR_W     = 32;
  localparam int INSN_W     = 64;
  localparam int LEN_W      = 4;
  localparam int REG_IDX_W  = 3;
  localparam int UPC_W      = 8;
  localparam int STAGES     = 6;
  // ----------------------------------------
  // Reset values and opcode fields
  // ----------------------------------------
  localparam logic [ADDR_W-1:0] RESET_PC = 32'hFFFF_FFF0;
  localparam logic [7:0] OP_JMP    = 8'hE9;
  localparam logic [7:0] OP_JCC_LO = 8'h70;
  localparam logic [7:0] OP_JCC_HI = 8'h7F;
  localparam logic [7:0] OP_FPU_LO = 8'hD8;
  localparam logic [7:0] OP_FPU_HI = 8'hDF;
  localparam logic [7:0] OP_STORE  = 8'h89;
  localparam logic [7:0] OP_MEMMOD = 8'h8B;
  localparam logic [UPC_W-1:0] UPC_ONE = 8'h01;

  typedef enum logic [2:0] {
    SIP_T_ALU    = 3'h0,
    SIP_T_LOAD   = 3'h1,
    SIP_T_STORE  = 3'h2,
    SIP_T_BRANCH = 3'h3,
    SIP_T_FPU    = 3'h4
  } sip_type_t;

  // Execute sequencer, Gray coded along idle -> run -> done
  typedef enum logic [1:0] {
    SIP_EX_IDLE = 2'b00,
    SIP_EX_RUN  = 2'b01,
    SIP_EX_DONE = 2'b11
  } sip_ex_t;
endpackage

// ---- testbench/sip_far_side.sv ----
// Cache, load/store and FPU stand-in on the pipeline's far side
`timescale 1ns/1ps
module sip_far_side
  import sip_pkg::*;
(
  // Clock, reset and run controls
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              slow,
  input  wire logic              fault_on,
  // Code fetch
  input  wire logic              ifetch_req,
  input  wire logic [ADDR_W-1:0] ifetch_addr,
  output logic                   ifetch_ack,
  output logic [FETCH_W-1:0]     ifetch_data,
  // Operand access
  input  wire logic              dmem_req,
  input  wire logic [ADDR_W-1:0] dmem_lin_addr,
  output logic                   dmem_ack,
  output logic                   dmem_fault,
  output logic [BUS_W-1:0]       dmem_rdata,
  // Dispatch and store sinks
  output logic                   fpu_ready,
  output logic                   lsu_ready
);
  logic [7:0] code [256];
  logic       stall_reg;
  logic [7:0] junk_reg;
  // ----------------------------------------
  // Stall pacing
  // ----------------------------------------
  // Junk changes each cycle out of reset so an unacked bus never repeats old data
  always_ff @(posedge clk) begin
    stall_reg <= slow && !stall_reg;
    junk_reg  <= rst_n ? junk_reg + 8'h5B : 8'hA5;
  end
  // ----------------------------------------
  // Answers
  // ----------------------------------------
  always_comb begin
    ifetch_ack = ifetch_req && !stall_reg;
    for (int i = 0; i < FETCH_BYTES; i++) begin
      ifetch_data[8*i +: 8] = ifetch_ack ?
        code[ifetch_addr[7:0] + 8'(i)] : junk_reg;
    end
  end
  assign dmem_ack   = dmem_req && !stall_reg;
  assign dmem_fault = dmem_ack && fault_on;
  assign dmem_rdata = dmem_ack ? {dmem_lin_addr, ~dmem_lin_addr} :
                      {8{junk_reg}};
  // Dispatched work is absorbed with no reply to the pipeline
  assign fpu_ready  = !stall_reg;
  assign lsu_ready  = !stall_reg;
endmodule

// ---- testbench/sip_pipe_assertions.sv ----
// Port-level assertions for the pipeline control
`timescale 1ns/1ps
module sip_pipe_assertions
  import sip_pkg::*;
(
  // Clock and reset
  input wire logic              clk,
  input wire logic              rst_n,
  // Memory side
  input wire logic              ifetch_req,
  input wire logic [ADDR_W-1:0] ifetch_addr,
  input wire logic              dmem_req,
  input wire logic [ADDR_W-1:0] dmem_lin_addr,
  input wire logic              dmem_ack,
  input wire logic              dmem_fault,
  input wire logic [BUS_W-1:0]  dmem_rdata,
  // Dispatch and results
  input wire logic              fpu_valid,
  input wire logic [BUS_W-1:0]  fpu_operand,
  input wire logic              lsu_valid,
  input wire logic [ADDR_W-1:0] lsu_addr,
  input wire logic [BUS_W-1:0]  lsu_wdata,
  input wire logic              lsu_ready,
  input wire logic              rf_we,
  input wire logic              mispredict,
  input wire logic              mem_fault
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_bad_ack;
    dmem_req && dmem_ack && dmem_fault;
  endsequence
  sequence s_lsu_wait;
    lsu_valid && !lsu_ready && !mispredict;
  endsequence
  a_reset_state: assert property (
    !$past(rst_n) |-> ifetch_req && ifetch_addr == RESET_PC &&
    !fpu_valid && !lsu_valid && !rf_we)
    else $error("state after reset wrong");
  a_dmem_hold: assert property (
    dmem_req && !dmem_ack && !mispredict |=>
    mispredict || (dmem_req && $stable(dmem_lin_addr)))
    else $error("operand request dropped before ack");
  a_lsu_hold: assert property (s_lsu_wait |=>
    lsu_valid && $stable(lsu_addr) && $stable(lsu_wdata))
    else $error("store hand-off changed before ready");
  a_fpu_after_ack: assert property (fpu_valid |-> dmem_ack)
    else $error("fpu dispatch without operand");
  a_fpu_operand: assert property (
    fpu_valid |-> fpu_operand == dmem_rdata)
    else $error("fpu operand not the fetched data");
  a_fault_next: assert property (s_bad_ack |=> mem_fault)
    else $error("fault not reported");
  a_fault_cause: assert property (
    mem_fault |-> $past(dmem_req && dmem_ack && dmem_fault))
    else $error("fault reported without cause");
  a_flush_pulse: assert property (mispredict |=> !mispredict)
    else $error("flush longer than one cycle");
endmodule
bind sip_pipe sip_pipe_assertions i_chk (.clk, .rst_n, .ifetch_req,
  .ifetch_addr, .dmem_req, .dmem_lin_addr, .dmem_ack, .dmem_fault,
  .dmem_rdata, .fpu_valid, .fpu_operand, .lsu_valid, .lsu_addr,
  .lsu_wdata, .lsu_ready, .rf_we, .mispredict, .mem_fault);

// ---- testbench/sip_pipe_test.sv ----
// Self-checking bench for the six-stage pipeline control
`timescale 1ns/1ps
module sip_pipe_test
  import sip_pkg::*;
;
  typedef struct {
    logic [7:0] op;
    logic       tk;
    int         fp;
    int         ls;
    int         mp;
  } sip_row_t;
  logic                 clk = 1'b0, rst_n = 1'b0, br_taken = 1'b1;
  logic                 slow = 1'b0, fault_on = 1'b0;
  logic                 ifetch_req, ifetch_ack, dmem_req, dmem_ack;
  logic                 dmem_fault, fpu_valid, fpu_ready, lsu_valid;
  logic                 lsu_ready, rf_we, mispredict, mem_fault, seen_tgt;
  logic [ADDR_W-1:0]    ifetch_addr, dmem_lin_addr, lsu_addr, tgt;
  logic [ADDR_W-1:0]    fetch_a [2];
  logic [FETCH_W-1:0]   ifetch_data;
  logic [BUS_W-1:0]     dmem_rdata, fpu_operand, lsu_wdata, rf_wdata;
  logic [INSN_W-1:0]    fpu_insn;
  logic [REG_IDX_W-1:0] rf_waddr;
  logic [7:0]           fpu_op;
  int n_fpu, n_lsu, n_mis, n_flt, n_fetch, err_total = 0, num_checks = 0;
  // Opcode, branch outcome, then dispatches, stores and flushes
  sip_row_t rows [9] = '{'{8'h90, 1'b1, 0, 0, 0}, '{8'h8B, 1'b1, 0, 0, 0},
    '{8'h89, 1'b1, 0, 1, 0}, '{8'hD8, 1'b1, 1, 0, 0},
    '{8'hDF, 1'b1, 1, 0, 0}, '{8'hE9, 1'b1, 0, 0, 0},
    '{8'hE9, 1'b0, 0, 0, 1}, '{8'h70, 1'b0, 0, 0, 1},
    '{8'h7F, 1'b1, 0, 0, 0}};
  always #50 clk = ~clk;
  sip_pipe i_dut (.clk, .rst_n, .ifetch_req, .ifetch_addr, .ifetch_ack,
    .ifetch_data, .dmem_req, .dmem_lin_addr, .dmem_ack, .dmem_fault,
    .dmem_rdata, .fpu_valid, .fpu_insn, .fpu_operand, .fpu_ready,
    .lsu_valid, .lsu_addr, .lsu_wdata, .lsu_ready, .rf_we, .rf_waddr,
    .rf_wdata, .br_taken, .mispredict, .mem_fault);
  sip_far_side i_far (.clk, .rst_n, .slow, .fault_on, .ifetch_req,
    .ifetch_addr, .ifetch_ack, .ifetch_data, .dmem_req, .dmem_lin_addr,
    .dmem_ack, .dmem_fault, .dmem_rdata, .fpu_ready, .lsu_ready);
  // ----------------------------------------
  // Monitor, sampled mid-cycle where outputs are settled
  // ----------------------------------------
  always @(negedge clk) begin
    if (fpu_valid && fpu_ready) begin
      n_fpu++;
      fpu_op = fpu_insn[7:0];
    end
    if (lsu_valid && lsu_ready) n_lsu++;
    if (mispredict) n_mis++;
    if (mem_fault) n_flt++;
    if (ifetch_req && ifetch_addr === tgt) seen_tgt = 1'b1;
    if (ifetch_req && ifetch_ack && n_fetch < 2) begin
      fetch_a[n_fetch] = ifetch_addr;
      n_fetch++;
    end
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk_cnt(input int got, input int exp);
    num_checks++;
    if (got != exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  task automatic chk_val(input logic [ADDR_W-1:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  // One instruction at the reset address, padded with one-byte ops
  task automatic run_prog(input logic [7:0] op, b1, input logic tk, sl, ft);
    for (int i = 0; i < 256; i++) i_far.code[i] = (i > 8'hF0 &&
      i < 8'hF6) ? 8'h00 : 8'h90;
    i_far.code[8'hF0] = op;
    i_far.code[8'hF1] = b1;
    @(posedge clk);
    #1 rst_n = 1'b0;
    br_taken = tk;
    slow = sl;
    fault_on = ft;
    repeat (6) @(posedge clk);
    #1 {n_fpu, n_lsu, n_mis, n_flt, n_fetch} = '0;
    seen_tgt = 1'b0;
    rst_n = 1'b1;
    repeat (60) @(posedge clk);
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    tgt = 32'h0000_0015;
    repeat (6) @(posedge clk);
    // Second pass repeats every row with the far side stalling
    for (int s = 0; s < 2; s++) begin
      foreach (rows[k]) begin
        run_prog(rows[k].op, 8'h00, rows[k].tk, 1'(s), 1'b0);
        chk_cnt(n_fpu, rows[k].fp);
        chk_cnt(n_lsu, rows[k].ls);
        chk_cnt(n_mis, rows[k].mp);
        if (rows[k].fp > 0) chk_val(32'(fpu_op), 32'(rows[k].op));
      end
    end
    // Faulting load, plus the first two fetch addresses
    run_prog(8'h8B, 8'h00, 1'b1, 1'b0, 1'b1);
    chk_cnt(n_flt, 1);
    chk_val(fetch_a[0], RESET_PC);
    chk_val(fetch_a[1], RESET_PC + 32'h10);
    // Taken jump with a non-zero offset lands on its target
    run_prog(8'hE9, 8'h20, 1'b1, 1'b0, 1'b0);
    chk_cnt(int'(seen_tgt), 1);
    chk_cnt(n_mis, 0);
    give_verdict();
  end
endmodule
